// ==== hdl/vsp_pkg.sv ====
// shared constants, types and helpers for the blanking data slicer packer
package vsp_pkg;

  // ==========================================================
  // line ranges
  localparam logic [9:0] LINE_FIRST     = 10'h006;
  localparam logic [9:0] LINE_LAST      = 10'h01b;
  localparam logic [9:0] LINE_LATE      = 10'h018;
  localparam int         LINES_PER_FLD  = 22;
  localparam int         NUM_MODE       = 2 * LINES_PER_FLD + 1;
  localparam logic [5:0] FULL_FIELD_IDX = 6'h2c;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_RESULT     = 8'h90;
  localparam logic [7:0] ADDR_RESULT_END = 8'haf;
  localparam logic [7:0] ADDR_FIFO       = 8'hb0;
  localparam logic [7:0] ADDR_CRAM       = 8'hc3;
  localparam logic [7:0] ADDR_LMODE      = 8'hd0;
  localparam logic [7:0] ADDR_FULLFIELD  = 8'hfc;
  localparam logic [7:0] LMODE_RESET     = 8'hff;
  localparam int         ROUTE_FIFO_BIT  = 4;
  localparam int         ROUTE_RES_BIT   = 5;

  // ==========================================================
  // service codes in the low nibble of a line-mode entry
  localparam logic [3:0] SVC_TTX_LAST = 4'h5;
  localparam logic [3:0] SVC_CAP_PAL  = 4'h6;
  localparam logic [3:0] SVC_PROG_SYS = 4'hc;
  localparam logic [3:0] SVC_ACTIVE   = 4'hf;

  // ==========================================================
  // packet layout
  localparam logic [7:0] PRE_ZERO     = 8'h00;
  localparam logic [7:0] PRE_ONES     = 8'hff;
  localparam logic [7:0] FILL_BYTE    = 8'h00;
  localparam logic [2:0] TYPE_PATTERN = 3'b010;
  localparam logic [6:0] IDX_TYPE     = 7'h03;
  localparam logic [6:0] IDX_FORMAT   = 7'h04;
  localparam logic [6:0] IDX_WCOUNT   = 7'h05;
  localparam logic [6:0] IDX_LINE_LO  = 7'h06;
  localparam logic [6:0] IDX_LINE_HI  = 7'h07;
  localparam logic [6:0] IDX_PAYLOAD  = 7'h08;
  localparam logic [6:0] PKT_OVERHEAD = 7'h09;
  localparam int         RES_SLOT     = 4;

  typedef struct packed {
    logic       field;
    logic [9:0] num;
  } vsp_line_t;

  typedef struct packed {
    logic match1;
    logic match2;
    logic errDet;
  } vsp_flags_t;

  typedef struct packed {
    logic [7:0] ptype;
    logic [7:0] fmt;
    logic [7:0] wcount;
    logic [7:0] lineLo;
    logic [7:0] lineHi;
    logic [7:0] cs;
  } vsp_hdr_t;

  // even parity in bit 6, its inverse in bit 7
  function automatic logic [7:0] vsp_parity(input logic [5:0] d);
    vsp_parity = {~(^d), ^d, d};
  endfunction : vsp_parity

endpackage : vsp_pkg

// ==== hdl/vsp_mem.sv ====
// simple dual-port byte memory with registered read data
`timescale 1ns/100ps
module vsp_mem #(
  parameter int W = 8,
  parameter int D = 64,
  parameter int A = $clog2(D)
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         wrEn,
  input  wire logic [A-1:0] wrAddr,
  input  wire logic [W-1:0] wrData,
  input  wire logic [A-1:0] rdAddr,
  output logic      [W-1:0] rdData
);
  logic [W-1:0] store [D];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData <= '0;
    end else begin
      rdData <= store[rdAddr];
    end
  end
endmodule : vsp_mem

// ==== hdl/vsp_fifo.sv ====
// byte fifo; popData shows the head taken at the pop edge
`timescale 1ns/100ps
module vsp_fifo #(
  parameter int W = 8,
  parameter int D = 512
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         push,
  input  wire logic [W-1:0] pushData,
  input  wire logic         pop,
  output logic      [W-1:0] popData,
  output logic              empty,
  output logic              full
);
  localparam int A = $clog2(D);
  logic [A:0] wrPtr_reg, wrPtr_next;
  logic [A:0] rdPtr_reg, rdPtr_next;
  logic       doPush, doPop;

  assign empty  = (wrPtr_reg == rdPtr_reg);
  assign full   = (wrPtr_reg[A] != rdPtr_reg[A]) &&
                  (wrPtr_reg[A-1:0] == rdPtr_reg[A-1:0]);
  assign doPush = push && !full;
  assign doPop  = pop && !empty;

  always_comb begin
    wrPtr_next = wrPtr_reg + (A+1)'(doPush);
    rdPtr_next = rdPtr_reg + (A+1)'(doPop);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
    end
  end

  vsp_mem #(.W(W), .D(D)) u_store (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wrEn    (doPush),
    .wrAddr  (wrPtr_reg[A-1:0]),
    .wrData  (pushData),
    .rdAddr  (rdPtr_reg[A-1:0]),
    .rdData  (popData)
  );

  // ==========================================================
  // checks
  no_overrun_a: assert property (@(posedge clk_sys) disable iff (reset)
    full && !doPop |=> $stable(wrPtr_reg)) else $error("fifo overrun");
endmodule : vsp_fifo

// ==== hdl/vsp_top.sv ====
// blanking data slicer back end: line modes, results, fifo, packets
`timescale 1ns/100ps
module vsp_top
  import vsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 512,
  parameter int CRAM_DEPTH = 256,
  parameter int LBUF_DEPTH = 64
) (
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic [7:0]      regAddr,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  input  wire logic [7:0]      regWrData,
  output logic      [7:0]      regRdData,
  input  wire logic            lineStart,
  input  wire vsp_pkg::vsp_line_t  lineInfo,
  output logic      [3:0]      serviceSel,
  output logic                 sliceEnable,
  input  wire logic            sliceValid,
  input  wire logic [7:0]      sliceByte,
  input  wire logic            sliceDone,
  input  wire vsp_pkg::vsp_flags_t sliceFlags,
  input  wire logic            embeddedSync,
  input  wire logic            ancSlot,
  output logic                 ancValid,
  output logic      [7:0]      ancData,
  output logic                 fifoEmpty,
  output logic                 fifoFull
);
  import vsp_pkg::*;

  localparam int CA = $clog2(CRAM_DEPTH);
  localparam int LA = $clog2(LBUF_DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_SLOT, ST_SEND} vsp_state_t;

  function automatic logic isTeletext(input logic [3:0] svc);
    isTeletext = (svc <= SVC_TTX_LAST);
  endfunction : isTeletext

  // ==========================================================
  // host registers
  logic [7:0]    lmode_reg [NUM_MODE];
  logic [7:0]    lmode_next [NUM_MODE];
  logic [CA-1:0] cramPtr_reg, cramPtr_next;
  logic [7:0]    rdAddr_reg, rdAddr_next;
  logic [7:0]    lmRead_reg, lmRead_next;
  logic          rdEmpty_reg, rdEmpty_next;
  logic          isLmode, cramHit, fifoPop;
  logic [5:0]    lmIdx;
  logic [7:0]    cramRd, resRd, fifoRd;

  assign isLmode = (regAddr >= ADDR_LMODE) && (regAddr <= ADDR_FULLFIELD);
  assign lmIdx   = 6'(regAddr - ADDR_LMODE);
  assign cramHit = (regWrite || regRead) && (regAddr == ADDR_CRAM);
  assign fifoPop = regRead && (regAddr == ADDR_FIFO);

  always_comb begin
    lmode_next   = lmode_reg;
    cramPtr_next = cramPtr_reg;
    rdAddr_next  = rdAddr_reg;
    lmRead_next  = lmRead_reg;
    rdEmpty_next = rdEmpty_reg;
    if (regWrite && isLmode) begin
      lmode_next[lmIdx] = regWrData;
    end
    if (cramHit) begin
      cramPtr_next = cramPtr_reg + CA'(1);
    end
    if (regRead) begin
      rdAddr_next  = regAddr;
      lmRead_next  = isLmode ? lmode_reg[lmIdx] : 8'h00;
      rdEmpty_next = fifoEmpty;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_MODE; i++) begin
        lmode_reg[i] <= LMODE_RESET;
      end
      cramPtr_reg <= '0;
      rdAddr_reg  <= 8'h00;
      lmRead_reg  <= 8'h00;
      rdEmpty_reg <= 1'b1;
    end else begin
      lmode_reg   <= lmode_next;
      cramPtr_reg <= cramPtr_next;
      rdAddr_reg  <= rdAddr_next;
      lmRead_reg  <= lmRead_next;
      rdEmpty_reg <= rdEmpty_next;
    end
  end

  // read data one cycle after regRead; unmapped reads give zero
  always_comb begin
    regRdData = 8'h00;
    if (rdAddr_reg >= ADDR_RESULT && rdAddr_reg <= ADDR_RESULT_END) begin
      regRdData = resRd;
    end else if (rdAddr_reg == ADDR_FIFO) begin
      regRdData = rdEmpty_reg ? 8'h00 : fifoRd;
    end else if (rdAddr_reg == ADDR_CRAM) begin
      regRdData = cramRd;
    end else if (rdAddr_reg >= ADDR_LMODE &&
                 rdAddr_reg <= ADDR_FULLFIELD) begin
      regRdData = lmRead_reg;
    end
  end

  // read and write share the pointer, so one access = one entry
  vsp_mem #(.W(8), .D(CRAM_DEPTH)) u_cram (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wrEn    (regWrite && regAddr == ADDR_CRAM),
    .wrAddr  (cramPtr_reg),
    .wrData  (regWrData),
    .rdAddr  (cramPtr_reg),
    .rdData  (cramRd)
  );

  // ==========================================================
  // line lookup and payload collection
  vsp_state_t    state_reg, state_next;
  logic [7:0]    curMode_reg, curMode_next;
  vsp_line_t     curLine_reg, curLine_next;
  logic          collect_reg, collect_next;
  logic [LA-1:0] count_reg, count_next;
  logic [7:0]    paySum_reg, paySum_next;
  logic [5:0]    lookIdx;
  logic          inRange, takeByte, resWr;
  logic [4:0]    resAddr;

  assign inRange = (lineInfo.num >= LINE_FIRST) &&
                   (lineInfo.num <= LINE_LAST);
  assign lookIdx = inRange ?
    6'(lineInfo.num - LINE_FIRST) + (lineInfo.field ? 6'(LINES_PER_FLD)
                                                    : 6'h00)
    : FULL_FIELD_IDX;
  assign serviceSel  = curMode_reg[3:0];
  assign sliceEnable = collect_reg;
  // payload bytes while the packet buffer is busy are dropped
  assign takeByte = collect_reg && sliceValid && state_reg == ST_IDLE &&
                    count_reg != LA'(LBUF_DEPTH - 1);
  assign resWr = takeByte && curMode_reg[ROUTE_RES_BIT] &&
                 !isTeletext(curMode_reg[3:0]) &&
                 count_reg < LA'(RES_SLOT);
  assign resAddr = 5'({curMode_reg[3:0] == SVC_PROG_SYS ? 2'd3 :
                       2'(3'(curMode_reg[3:1]) - 3'(SVC_CAP_PAL[3:1])),
                       curLine_reg.field, count_reg[1:0]});

  always_comb begin
    curMode_next = curMode_reg;
    curLine_next = curLine_reg;
    collect_next = collect_reg;
    count_next   = count_reg;
    paySum_next  = paySum_reg;
    if (lineStart) begin
      curMode_next = lmode_reg[lookIdx];
      curLine_next = lineInfo;
      collect_next = (lmode_reg[lookIdx] != LMODE_RESET);
      count_next   = '0;
      paySum_next  = 8'h00;
    end else if (takeByte) begin
      count_next  = count_reg + LA'(1);
      paySum_next = paySum_reg + sliceByte;
    end else if (sliceDone) begin
      collect_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      curMode_reg <= LMODE_RESET;
      curLine_reg <= '0;
      collect_reg <= 1'b0;
      count_reg   <= '0;
      paySum_reg  <= 8'h00;
    end else begin
      curMode_reg <= curMode_next;
      curLine_reg <= curLine_next;
      collect_reg <= collect_next;
      count_reg   <= count_next;
      paySum_reg  <= paySum_next;
    end
  end

  vsp_mem #(.W(8), .D(32)) u_result (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wrEn    (resWr),
    .wrAddr  (resAddr),
    .wrData  (sliceByte),
    .rdAddr  (5'(regAddr - ADDR_RESULT)),
    .rdData  (resRd)
  );

  // ==========================================================
  // packet header build and emission
  vsp_hdr_t   hdr_reg, hdr_next, hdrNew;
  logic [6:0] total_reg, total_next, totalNew;
  logic [6:0] idx_reg, idx_next;
  logic       fifoEn_reg, fifoEn_next, emb_reg, emb_next;
  logic       startPkt, sending, lastByte;
  logic [7:0] bufRd, pktByte;
  logic [6:0] bufAddr;

  assign startPkt = collect_reg && sliceDone && state_reg == ST_IDLE;
  assign sending  = (state_reg == ST_SEND);
  assign lastByte = sending && idx_reg == total_reg - 7'd1;
  assign bufAddr  = idx_next - IDX_PAYLOAD;

  always_comb begin
    totalNew = (PKT_OVERHEAD + 7'(count_reg) + 7'd3) & 7'h7c;
    hdrNew.ptype = vsp_parity({TYPE_PATTERN, curLine_reg.field,
                               curLine_reg.num >= LINE_LATE, 1'b1});
    hdrNew.fmt = vsp_parity({2'b00, curMode_reg[3:0]});
    hdrNew.wcount = vsp_parity(6'((totalNew - IDX_PAYLOAD) >> 2));
    hdrNew.lineLo = curLine_reg.num[7:0];
    hdrNew.lineHi = {3'b000, sliceFlags.errDet, sliceFlags.match1,
                     sliceFlags.match2, curLine_reg.num[9:8]};
    hdrNew.cs = vsp_parity(6'(hdrNew.ptype + hdrNew.fmt + hdrNew.wcount +
                              hdrNew.lineLo + hdrNew.lineHi +
                              paySum_reg));
  end

  always_comb begin
    state_next  = state_reg;
    hdr_next    = hdr_reg;
    total_next  = total_reg;
    idx_next    = idx_reg;
    fifoEn_next = fifoEn_reg;
    emb_next    = emb_reg;
    unique case (state_reg)
      ST_IDLE: begin
        idx_next = 7'h00;
        if (startPkt) begin
          hdr_next    = hdrNew;
          total_next  = totalNew;
          fifoEn_next = curMode_reg[ROUTE_FIFO_BIT] ||
                        isTeletext(curMode_reg[3:0]);
          emb_next    = embeddedSync;
          if (embeddedSync) begin
            state_next = ST_WAIT_SLOT;
          end else if (fifoEn_next) begin
            state_next = ST_SEND;
          end
        end
      end
      ST_WAIT_SLOT: begin
        if (ancSlot) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        idx_next = idx_reg + 7'd1;
        if (lastByte) begin
          state_next = ST_IDLE;
          idx_next   = 7'h00;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg  <= ST_IDLE;
      hdr_reg    <= '0;
      total_reg  <= 7'h00;
      idx_reg    <= 7'h00;
      fifoEn_reg <= 1'b0;
      emb_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      hdr_reg    <= hdr_next;
      total_reg  <= total_next;
      idx_reg    <= idx_next;
      fifoEn_reg <= fifoEn_next;
      emb_reg    <= emb_next;
    end
  end

  always_comb begin
    if (idx_reg == 7'h00) begin
      pktByte = PRE_ZERO;
    end else if (idx_reg < IDX_TYPE) begin
      pktByte = PRE_ONES;
    end else if (idx_reg == IDX_TYPE) begin
      pktByte = hdr_reg.ptype;
    end else if (idx_reg == IDX_FORMAT) begin
      pktByte = hdr_reg.fmt;
    end else if (idx_reg == IDX_WCOUNT) begin
      pktByte = hdr_reg.wcount;
    end else if (idx_reg == IDX_LINE_LO) begin
      pktByte = hdr_reg.lineLo;
    end else if (idx_reg == IDX_LINE_HI) begin
      pktByte = hdr_reg.lineHi;
    end else if (idx_reg < IDX_PAYLOAD + 7'(count_reg)) begin
      pktByte = bufRd;
    end else if (idx_reg == IDX_PAYLOAD + 7'(count_reg)) begin
      pktByte = hdr_reg.cs;
    end else begin
      pktByte = FILL_BYTE;
    end
  end

  assign ancValid = sending && emb_reg;
  assign ancData  = ancValid ? pktByte : 8'h00;

  // payload written at count, read one cycle ahead of its slot
  vsp_mem #(.W(8), .D(LBUF_DEPTH)) u_lbuf (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wrEn    (takeByte),
    .wrAddr  (count_reg),
    .wrData  (sliceByte),
    .rdAddr  (bufAddr[LA-1:0]),
    .rdData  (bufRd)
  );

  // full fifo drops bytes rather than stall the video slot
  vsp_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .push     (sending && fifoEn_reg),
    .pushData (pktByte),
    .pop      (fifoPop),
    .popData  (fifoRd),
    .empty    (fifoEmpty),
    .full     (fifoFull)
  );

  // ==========================================================
  // checks
  cram_ptr_a: assert property (@(posedge clk_sys) disable iff (reset)
    cramHit |=> cramPtr_reg == $past(cramPtr_reg) + CA'(1))
    else $error("config pointer did not advance");
  ttx_route_a: assert property (@(posedge clk_sys) disable iff (reset)
    resWr |-> !isTeletext(curMode_reg[3:0]))
    else $error("teletext written to result block");
  preamble_a: assert property (@(posedge clk_sys) disable iff (reset)
    sending && idx_reg == 7'h00 |-> pktByte == 8'h00
      ##1 pktByte == 8'hff ##1 pktByte == 8'hff)
    else $error("bad preamble");
  type_form_a: assert property (@(posedge clk_sys) disable iff (reset)
    sending && idx_reg == IDX_TYPE |-> pktByte[5:3] == 3'b010 &&
      pktByte[6] == ^pktByte[5:0] && pktByte[7] == !pktByte[6])
    else $error("bad packet type byte");
  fill_end_a: assert property (@(posedge clk_sys) disable iff (reset)
    lastByte |-> total_reg[1:0] == 2'b00 &&
      (idx_reg > IDX_PAYLOAD + 7'(count_reg) ? pktByte == 8'h00 : 1'b1))
    else $error("packet not padded to four bytes");
  word_cnt_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(sending) |-> {hdr_reg.wcount[5:0], 2'b00} == total_reg - 7'd8)
    else $error("word count mismatch");
  slot_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(ancValid) |-> $past(ancSlot) && $past(state_reg == ST_WAIT_SLOT))
    else $error("packet sent outside blanking slot");
  line_pick_a: assert property (@(posedge clk_sys) disable iff (reset)
    lineStart && inRange |=> curMode_reg ==
      $past(lmode_reg[lookIdx]) && curLine_reg == $past(lineInfo))
    else $error("wrong line mode picked");
endmodule : vsp_top

// ==== tb/vsp_slicer_model.sv ====
// slicer front-end model feeding payload bytes to the packer
`timescale 1ns/100ps
module vsp_slicer_model (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                sliceEnable,
  input  wire logic [5:0]          nBytes,
  input  wire logic [63:0][7:0]    payload,
  input  wire vsp_pkg::vsp_flags_t flagsIn,
  input  wire logic                slow,
  output logic                     sliceValid,
  output logic      [7:0]          sliceByte,
  output logic                     sliceDone,
  output vsp_pkg::vsp_flags_t      sliceFlags
);
  import vsp_pkg::*;

  int   idx;
  logic fin;
  logic gap;

  // ==========================================================
  // byte delivery
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idx <= 0;
      fin <= 1'b0;
      gap <= 1'b0;
      sliceValid <= 1'b0;
      sliceDone <= 1'b0;
      sliceByte <= 8'h00;
      sliceFlags <= '0;
    end else begin
      sliceValid <= 1'b0;
      sliceDone <= 1'b0;
      // idle byte lines toggle and idle flags show ~flagsIn so stale data never looks valid
      sliceByte <= ~sliceByte;
      sliceFlags <= ~flagsIn;
      if (!sliceEnable) begin
        idx <= 0;
        fin <= 1'b0;
      end else if (!fin) begin
        gap <= slow & ~gap;
        if (!gap && idx < int'(nBytes)) begin
          // sync byte, when present, is payload[0]
          sliceValid <= 1'b1;
          sliceByte <= payload[idx];
          idx <= idx + 1;
        end else if (!gap) begin
          sliceDone <= 1'b1;
          sliceFlags <= flagsIn;
          fin <= 1'b1;
        end
      end
    end
  end
endmodule : vsp_slicer_model

// ==== tb/vsp_top_tb.sv ====
// self-checking bench for the slicer packet packer
`timescale 1ns/100ps
module vsp_top_tb;
  import vsp_pkg::*;

  localparam int         CRAM_N = 256;
  localparam logic [7:0] SYNC   = 8'h27;

  logic             clk_sys = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       regAddr = 8'h00;
  logic             regWrite = 1'b0;
  logic             regRead = 1'b0;
  logic [7:0]       regWrData = 8'h00;
  logic [7:0]       regRdData;
  logic             lineStart = 1'b0;
  vsp_line_t        lineInfo = '0;
  logic [3:0]       serviceSel;
  logic             sliceEnable;
  logic             sliceValid;
  logic [7:0]       sliceByte;
  logic             sliceDone;
  vsp_flags_t       sliceFlags;
  logic             embeddedSync = 1'b0;
  logic             ancSlot = 1'b0;
  logic             ancValid;
  logic [7:0]       ancData;
  logic             fifoEmpty;
  logic             fifoFull;
  logic [5:0]       nBytes = 6'd1;
  logic [63:0][7:0] payload = '0;
  vsp_flags_t       flagsIn = '0;
  logic             slow = 1'b0;
  int               seed;
  int               mismatches = 0;
  int               n_compared = 0;
  int               total;
  int               cyc = 0;
  logic [7:0]       exp [0:127];
  logic [7:0]       cram [0:CRAM_N-1];

  always #10 clk_sys = ~clk_sys;

  vsp_top #(.FIFO_DEPTH(512), .CRAM_DEPTH(CRAM_N), .LBUF_DEPTH(64))
  vsp_top_inst (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
    .regRdData(regRdData), .lineStart(lineStart), .lineInfo(lineInfo),
    .serviceSel(serviceSel), .sliceEnable(sliceEnable),
    .sliceValid(sliceValid), .sliceByte(sliceByte),
    .sliceDone(sliceDone), .sliceFlags(sliceFlags),
    .embeddedSync(embeddedSync), .ancSlot(ancSlot), .ancValid(ancValid),
    .ancData(ancData), .fifoEmpty(fifoEmpty), .fifoFull(fifoFull));

  vsp_slicer_model vsp_slicer_model_inst (.clk_sys(clk_sys),
    .reset(reset), .sliceEnable(sliceEnable), .nBytes(nBytes),
    .payload(payload), .flagsIn(flagsIn), .slow(slow),
    .sliceValid(sliceValid), .sliceByte(sliceByte),
    .sliceDone(sliceDone), .sliceFlags(sliceFlags));

  // ==========================================================
  // helpers
  function automatic logic [7:0] par(input logic [5:0] d);
    return {~(^d), ^d, d};
  endfunction : par

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(regRdData, want);
  endtask : rdc

  task automatic wait_en(input logic v);
    int k;
    k = 0;
    while (sliceEnable !== v && k < 300) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk({7'h0, sliceEnable}, {7'h0, v});
  endtask : wait_en

  task automatic build(input vsp_line_t li, input logic [3:0] svc);
    logic [7:0] s;
    s = 8'h00;
    total = (9 + int'(nBytes) + 3) / 4 * 4;
    for (int i = 0; i < 128; i++) exp[i] = 8'h00;
    exp[1] = 8'hff;
    exp[2] = 8'hff;
    if (li.field) exp[3] = (li.num >= 10'd24) ? 8'h97 : 8'h55;
    else exp[3] = (li.num >= 10'd24) ? 8'h53 : 8'h91;
    exp[4] = par({2'b00, svc});
    exp[5] = par(6'(total / 4 - 2));
    exp[6] = li.num[7:0];
    exp[7] = {3'b000, flagsIn.errDet, flagsIn.match1, flagsIn.match2,
              li.num[9:8]};
    for (int i = 0; i < int'(nBytes); i++) exp[8 + i] = payload[i];
    for (int i = 3; i < 8 + int'(nBytes); i++) s = s + exp[i];
    exp[8 + int'(nBytes)] = par(s[5:0]);
  endtask : build

  // path 0 stream, 1 fifo, 2 result block
  task automatic one_line(input vsp_line_t li, input logic [7:0] mode,
                          input int path);
    logic [7:0] a;
    int         k;
    a = ADDR_LMODE + 8'(li.field) * 8'd22 + 8'(li.num - 10'd6);
    @(posedge clk_sys);
    nBytes <= 6'd4 + 6'($unsigned($random(seed)) % 36);
    for (int i = 0; i < 64; i++)
      payload[i] <= (i == 0 && mode[3:0] <= SVC_TTX_LAST) ? SYNC
                    : 8'($random(seed));
    flagsIn <= vsp_flags_t'(3'($random(seed)));
    slow <= ~slow;
    wr(a, mode);
    @(posedge clk_sys);
    embeddedSync <= (path == 0);
    lineInfo <= li;
    lineStart <= 1'b1;
    @(posedge clk_sys);
    lineStart <= 1'b0;
    wait_en(1'b1);
    chk({4'h0, serviceSel}, {4'h0, mode[3:0]});
    wait_en(1'b0);
    build(li, mode[3:0]);
    if (path == 0) begin
      @(posedge clk_sys);
      ancSlot <= 1'b1;
      @(posedge clk_sys);
      ancSlot <= 1'b0;
      #1;
      k = 0;
      while (ancValid !== 1'b1 && k < 20) begin
        @(posedge clk_sys);
        #1;
        k++;
      end
      k = 0;
      while (ancValid === 1'b1 && k < 128) begin
        chk(ancData, exp[k]);
        k++;
        @(posedge clk_sys);
        #1;
      end
      chk(8'(k), 8'(total));
      chk(ancData, 8'h00);
      if (mode[4] || mode[3:0] <= SVC_TTX_LAST)
        for (int i = 0; i < total; i++) rdc(ADDR_FIFO, exp[i]);
      chk({7'h0, fifoEmpty}, 8'h01);
    end else if (path == 1) begin
      repeat (total + 4) @(posedge clk_sys);
      for (int i = 0; i < total; i++) rdc(ADDR_FIFO, exp[i]);
      chk({7'h0, fifoEmpty}, 8'h01);
      rdc(ADDR_FIFO, 8'h00);
    end else begin
      for (int i = 0; i < 4; i++)
        rdc(ADDR_RESULT + 8'(li.field) * 8'h04 + 8'(i), exp[8 + i]);
      chk({7'h0, fifoEmpty}, 8'h01);
    end
    wr(a, LMODE_RESET);
  endtask : one_line

  // ==========================================================
  // watchdog
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    vsp_line_t li;
    seed = 47;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk(regRdData, 8'h00);
    chk({4'h0, serviceSel}, 8'h0f);
    chk({4'h0, fifoEmpty, fifoFull, sliceEnable, ancValid}, 8'h08);
    rdc(ADDR_LMODE, LMODE_RESET);
    rdc(ADDR_FULLFIELD, LMODE_RESET);
    wr(8'h10, 8'h5a);
    rdc(8'h10, 8'h00);
    $display("test reset and map done");
    for (int i = 0; i < CRAM_N; i++) begin
      cram[i] = 8'($random(seed));
      wr(ADDR_CRAM, cram[i]);
    end
    for (int i = 0; i < CRAM_N; i++) rdc(ADDR_CRAM, cram[i]);
    $display("test config ram done");
    for (int i = 0; i < 14; i++) begin
      li.field = 1'($random(seed));
      li.num = 10'd6 + 10'($unsigned($random(seed)) % 22);
      if (i < 3) li.num = (i == 0) ? 10'd6 : (i == 1) ? 10'd24 : 10'd27;
      one_line(li, {3'h0, 1'(i), (i < 13) ? 4'(i) : SVC_ACTIVE}, 0);
    end
    $display("test stream packets done");
    li.field = 1'b1;
    li.num = 10'd23;
    one_line(li, 8'h24, 1);
    $display("test fifo done");
    li.num = 10'd21;
    one_line(li, 8'h27, 2);
    $display("test result block done");
    final_report;
  end
endmodule : vsp_top_tb
